// [design/pdm_rec_pkg.sv]
package pdm_rec_pkg;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [7:0] REG_CLK_CFG  = 8'h00;
    localparam logic [7:0] REG_EDGE_CFG = 8'h04;
    localparam logic [7:0] REG_CH1_CFG  = 8'h08;
    localparam logic [7:0] REG_CH2_CFG  = 8'h0C;
    localparam logic [7:0] REG_VAD_CFG  = 8'h10;
    localparam logic [7:0] REG_AGC_CFG  = 8'h14;
    localparam logic [7:0] REG_STATUS   = 8'h18;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CLK_DIV_LSB   = 0;
    localparam int CLK_FAM44_BIT = 2;
    localparam int CLK_AUXO_BIT  = 3;
    localparam int CLK_BIDIR_BIT = 4;
    localparam int DATA2_BID_BIT = 5;
    localparam int CH34_EN_LSB   = 6;
    localparam int EDGE_LSB      = 4;
    localparam int SRC_LSB       = 5;
    localparam int VOICE_DETECT_ENABLE_BIT    = 0;
    localparam int VAD_CH_LSB    = 4;
    localparam int VAD_RESP_LSB  = 6;
    localparam int AGC_MAX_LSB   = 0;
    localparam int GAIN_CTRL_TARGET_LEVEL_LSB   = 4;
    localparam int AGC_MAN_LSB   = 8;
    localparam int AGC_EN_BIT    = 12;
    localparam int ST_FLAG_BIT   = 4;
    localparam int ST_GAIN_LSB   = 8;
    localparam int ST_APD_LSB    = 12;
    localparam int ST_REC_BIT    = 14;

    // ****************************************
    // codes and reset values
    // ****************************************
    localparam logic [1:0] SRC_ANALOG   = 2'h0;
    localparam logic [1:0] SRC_DIGITAL  = 2'h1;
    localparam logic [1:0] RESP_IRQ     = 2'h0;
    localparam logic [1:0] RESP_WAKE    = 2'h1;
    localparam logic [3:0] GAIN_CTRL_TARGET_LEVEL_RST  = 4'hE;
    localparam logic [3:0] AGC_MAX_RST  = 4'h7;
    localparam logic [3:0] AGC_MAX_CODE = 4'hF;

    // ****************************************
    // bit clock synthesis at 100 MHz
    // ****************************************
    localparam real        CLOCK_MHZ    = 100.0;
    localparam real        MIC_MHZ_48   = 6.144;
    localparam real        MIC_MHZ_44   = 5.6448;
    localparam logic [31:0] INC_48 = 32'(longint'(MIC_MHZ_48 / CLOCK_MHZ * 4294967296.0));
    localparam logic [31:0] INC_44 = 32'(longint'(MIC_MHZ_44 / CLOCK_MHZ * 4294967296.0));

    // ****************************************
    // decimation and voice detection
    // ****************************************
    localparam int DECIM_RATIO     = 64;
    localparam real ULL_DELAY_192K = 3.7;
    localparam real ULL_DELAY_384K = 4.1;
    localparam logic [15:0] VAD_THRESH_RST = 16'h0400;
    localparam logic [15:0] PCM_MAX = 16'h7FFF;
    localparam logic [7:0]  SQRT2_Q7 = 8'hB5;

    // target amplitude for -6 dB .. -36 dB in 2 dB steps
    localparam logic [15:0] TARGET_AMP [16] = '{
        16'h4027, 16'h32F5, 16'h287A, 16'h2027, 16'h198A, 16'h1449, 16'h101D, 16'h0CCD,
        16'h0A2B, 16'h0813, 16'h066A, 16'h0518, 16'h040C, 16'h0337, 16'h028E, 16'h0207};

    typedef enum logic [1:0] {
        REC_RUN    = 2'b00,
        REC_LISTEN = 2'b01,
        REC_WOKEN  = 2'b10
    } rec_state_e;

endpackage : pdm_rec_pkg

// [design/pdm_bits_if.sv]
`timescale 1ns/10ps
interface pdm_bits_if #(parameter int NCH = 4, parameter int W = 8);
    logic [NCH-1:0]   bitStrobe;
    logic [NCH-1:0]   bitVal;
    logic             frameTick;
    logic [NCH*W-1:0] raw;
    logic             rawValid;
    modport sampler (output bitStrobe, output bitVal, output frameTick,
                     input raw, input rawValid);
    modport decim   (input bitStrobe, input bitVal, input frameTick,
                     output raw, output rawValid);
endinterface : pdm_bits_if

// [design/pdm_decimator.sv]
`timescale 1ns/10ps
module pdm_decimator
    import pdm_rec_pkg::*;
#(
    parameter int NCH   = 4,
    parameter int DECIM = DECIM_RATIO,
    parameter int W     = $clog2(DECIM) + 2
)(
    input  wire logic clock,
    input  wire logic nrst,
    pdm_bits_if.decim bits
);
    // ****************************************
    // boxcar decimation, one frame per DECIM bit periods
    // ****************************************
    localparam logic [W-1:0] FRAME_LAST = W'(DECIM - 1);
    localparam logic [W-1:0] DECIM_W    = W'(DECIM);

    logic [W-1:0] frameCnt_q;
    logic         rawValid_q;
    wire          frameEnd = bits.frameTick && (frameCnt_q == FRAME_LAST);

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            frameCnt_q <= '0;
        else if (bits.frameTick)
            frameCnt_q <= frameEnd ? '0 : frameCnt_q + 1'b1;

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            rawValid_q <= 1'b0;
        else
            rawValid_q <= frameEnd;

    genvar i;
    generate
        for (i = 0; i < NCH; i++)
        begin : g_ch
            logic [W-1:0] ones_q;
            logic [W-1:0] raw_q;
            wire  [W-1:0] addBit = W'(bits.bitStrobe[i] && bits.bitVal[i]);
            wire  [W-1:0] total  = ones_q + addBit;
            // each strobe belongs to one channel only, so the two mics on a
            // shared line never mix
            always_ff @(posedge clock or negedge nrst)
                if (!nrst)
                begin
                    ones_q <= '0;
                    raw_q  <= '0;
                end
                else if (frameEnd)
                begin
                    ones_q <= '0;
                    raw_q  <= (total << 1) - DECIM_W;
                end
                else
                    ones_q <= total;
            assign bits.raw[i*W +: W] = raw_q;
        end
    endgenerate

    // short boxcar keeps latency within a few output samples
    // at the highest rates as well
    assign bits.rawValid = rawValid_q;

endmodule : pdm_decimator

// [design/pdm_mic_record.sv]
`timescale 1ns/10ps
module pdm_mic_record
    import pdm_rec_pkg::*;
#(
    parameter int          NCH        = 4,
    parameter int          DECIM      = DECIM_RATIO,
    parameter int          PCM_W      = 16,
    parameter logic [15:0] VAD_THRESH = VAD_THRESH_RST
)(
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic               auxInputPinFirst,
    input  wire logic               micBiasPinIn,
    output logic                    auxOutputPinFirst,
    input  wire logic               bidirAuxPinIn,
    output logic                    bidirAuxPinOut,
    output logic                    bidirAuxPinOe_n,
    input  wire logic [2*PCM_W-1:0] analogPcm,
    output logic [1:0]              analogPowerDown,
    output logic                    voiceAlert,
    output logic                    pcmValid,
    output logic [NCH*PCM_W-1:0]    pcmOut
);
    localparam int W = $clog2(DECIM) + 2;

    // ****************************************
    // bus slave, zero wait states
    // ****************************************
    logic       wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdMux;

    wire addrPhase = hsel && htrans[1] && hready;

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
            hrdata_q <= '0;
        end
        else
        begin
            wrPend_q <= addrPhase && hwrite;
            wrAddr_q <= haddr[7:0];
            hrdata_q <= (addrPhase && !hwrite) ? rdMux : '0;
        end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    wire wrClk  = wrPend_q && (wrAddr_q == REG_CLK_CFG);
    wire wrEdge = wrPend_q && (wrAddr_q == REG_EDGE_CFG);
    wire wrCh1  = wrPend_q && (wrAddr_q == REG_CH1_CFG);
    wire wrCh2  = wrPend_q && (wrAddr_q == REG_CH2_CFG);
    wire wrVad  = wrPend_q && (wrAddr_q == REG_VAD_CFG);
    wire wrAgc  = wrPend_q && (wrAddr_q == REG_AGC_CFG);
    wire wrStat = wrPend_q && (wrAddr_q == REG_STATUS);

    // ****************************************
    // configuration registers
    // ****************************************
    logic [7:0]  clkCfg_q;
    logic [3:0]  edgeSel_q;
    logic [1:0]  ch1Src_q;
    logic [1:0]  ch2Src_q;
    logic [7:0]  vadCfg_q;
    logic [12:0] agcCfg_q;

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            clkCfg_q  <= '0;
            edgeSel_q <= '0;
            ch1Src_q  <= SRC_ANALOG;
            ch2Src_q  <= SRC_ANALOG;
            vadCfg_q  <= '0;
            agcCfg_q  <= {1'b0, 4'h0, GAIN_CTRL_TARGET_LEVEL_RST, AGC_MAX_RST};
        end
        else
        begin
            if (wrClk)  clkCfg_q  <= hwdata[7:0];
            if (wrEdge) edgeSel_q <= hwdata[EDGE_LSB +: 4];
            if (wrCh1)  ch1Src_q  <= hwdata[SRC_LSB +: 2];
            if (wrCh2)  ch2Src_q  <= hwdata[SRC_LSB +: 2];
            if (wrVad)  vadCfg_q  <= hwdata[7:0];
            if (wrAgc)  agcCfg_q  <= hwdata[12:0];
        end

    wire [1:0] divSel      = clkCfg_q[CLK_DIV_LSB +: 2];
    wire       family44    = clkCfg_q[CLK_FAM44_BIT];
    wire       data2Bidir  = clkCfg_q[DATA2_BID_BIT];
    wire       vadEn       = vadCfg_q[VOICE_DETECT_ENABLE_BIT];
    wire [1:0] vadCh       = vadCfg_q[VAD_CH_LSB +: 2];
    wire [1:0] vadResp     = vadCfg_q[VAD_RESP_LSB +: 2];
    wire [3:0] maxGain     = agcCfg_q[AGC_MAX_LSB +: 4];
    wire [3:0] targetCode  = agcCfg_q[GAIN_CTRL_TARGET_LEVEL_LSB +: 4];
    wire [3:0] manualGain  = agcCfg_q[AGC_MAN_LSB +: 4];
    wire       agcEn       = agcCfg_q[AGC_EN_BIT];

    // ch3/ch4 have no analog path, only an enable
    wire [3:0] chDigital = {clkCfg_q[CH34_EN_LSB +: 2],
                            ch2Src_q == SRC_DIGITAL, ch1Src_q == SRC_DIGITAL};
    assign analogPowerDown = chDigital[1:0];

    // ****************************************
    // bit clock synthesis
    // ****************************************
    // phase accumulator: 100 MHz is not a multiple of either family, so the
    // edges jitter by one cycle while the mean rate is exact
    logic [31:0] phase_q;
    logic        micClkPrev_q;
    wire         anyDigital = |chDigital;
    wire  [31:0] phaseInc   = (family44 ? INC_44 : INC_48) >> divSel;
    wire         micClk     = phase_q[31];

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            phase_q      <= '0;
            micClkPrev_q <= 1'b0;
        end
        else
        begin
            phase_q      <= anyDigital ? phase_q + phaseInc : '0;
            micClkPrev_q <= micClk;
        end

    wire rise = micClk && !micClkPrev_q;
    wire fall = !micClk && micClkPrev_q;

    // ****************************************
    // pin routing
    // ****************************************
    // channel-two pins serve the mics only while channel two is not analog
    wire ch2Free     = ch2Src_q != SRC_ANALOG;
    wire clkOnAux    = clkCfg_q[CLK_AUXO_BIT] && ch2Free;
    wire clkOnBidir  = clkCfg_q[CLK_BIDIR_BIT] && !data2Bidir;
    wire dataFirst   = ch2Free && auxInputPinFirst;
    wire dataSecond  = data2Bidir ? bidirAuxPinIn : micBiasPinIn;

    assign auxOutputPinFirst = clkOnAux && micClk;
    assign bidirAuxPinOut    = micClk;
    assign bidirAuxPinOe_n   = !clkOnBidir;

    // ****************************************
    // edge sampling and decimation
    // ****************************************
    pdm_bits_if #(.NCH(NCH), .W(W)) bits ();

    genvar i;
    generate
        for (i = 0; i < NCH; i++)
        begin : g_smp
            // the partner mic drives on the opposite edge
            assign bits.bitStrobe[i] = chDigital[i] && (edgeSel_q[i] ? rise : fall);
            assign bits.bitVal[i]    = (i < 2) ? dataFirst : dataSecond;
        end
    endgenerate
    assign bits.frameTick = rise;

    pdm_decimator #(.NCH(NCH), .DECIM(DECIM), .W(W)) u_decim (
        .clock (clock),
        .nrst  (nrst),
        .bits  (bits)
    );

    // ****************************************
    // gain stage
    // ****************************************
    // gain code g means 3*(g+1) dB: shift per 6 dB, sqrt2 for the odd 3 dB
    function automatic logic signed [PCM_W-1:0] applyGain(
        input logic signed [PCM_W-1:0] x, input logic [3:0] code);
        logic [4:0]         steps;
        logic signed [31:0] w;
        steps = {1'b0, code} + 5'h01;
        w     = 32'(x);
        if (steps[0])
            w = (w * $signed({24'h0, SQRT2_Q7})) >>> 7;
        w = w <<< steps[4:1];
        if (w > $signed({16'h0, PCM_MAX}))
            w = $signed({16'h0, PCM_MAX});
        else if (w < -$signed({16'h0, PCM_MAX}))
            w = -$signed({16'h0, PCM_MAX});
        return w[PCM_W-1:0];
    endfunction : applyGain

    logic [3:0]             agcGain_q;
    logic                   pcmValid_q;
    logic signed [PCM_W-1:0] chPre  [NCH];
    logic signed [PCM_W-1:0] chGain [NCH];
    rec_state_e             state_q;

    wire [3:0] gainCode  = agcEn ? agcGain_q : manualGain;
    wire       recording = state_q != REC_LISTEN;

    generate
        for (i = 0; i < NCH; i++)
        begin : g_pcm
            logic [PCM_W-1:0] out_q;
            // full-density stream lands near half scale, keeps voice threshold reachable
            wire signed [PCM_W-1:0] dig = PCM_W'($signed(bits.raw[i*W +: W])) <<< (PCM_W - W);
            // analog samples enter only on channels one and two
            if (i < 2)
            begin : g_ana
                assign chPre[i] = chDigital[i] ? dig : $signed(analogPcm[i*PCM_W +: PCM_W]);
            end
            else
            begin : g_dig
                assign chPre[i] = chDigital[i] ? dig : '0;
            end
            assign chGain[i] = applyGain(chPre[i], gainCode);
            always_ff @(posedge clock or negedge nrst)
                if (!nrst)
                    out_q <= '0;
                else if (bits.rawValid)
                    out_q <= chGain[i];
            assign pcmOut[i*PCM_W +: PCM_W] = out_q;
        end
    endgenerate

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            pcmValid_q <= 1'b0;
        else
            pcmValid_q <= bits.rawValid && recording;
    assign pcmValid = pcmValid_q;

    // ****************************************
    // automatic gain control
    // ****************************************
    wire signed [PCM_W-1:0] watchPre  = chPre[vadCh];
    wire signed [PCM_W-1:0] watchGain = chGain[vadCh];
    wire [PCM_W-1:0] gainMag = watchGain[PCM_W-1] ? PCM_W'(-watchGain) : watchGain;
    wire [PCM_W-1:0] preMag  = watchPre[PCM_W-1] ? PCM_W'(-watchPre) : watchPre;
    wire [PCM_W-1:0] target  = TARGET_AMP[targetCode];
    wire tooLoud = gainMag > target;
    wire tooSoft = gainMag < target;

    // a lowered cap pulls the gain down at once
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            agcGain_q <= '0;
        else if (agcGain_q > maxGain)
            agcGain_q <= maxGain;
        else if (agcEn && bits.rawValid)
        begin
            if (tooLoud && agcGain_q != 4'h0)
                agcGain_q <= agcGain_q - 4'h1;
            else if (tooSoft && agcGain_q < maxGain)
                agcGain_q <= agcGain_q + 4'h1;
        end

    // ****************************************
    // voice activity detection
    // ****************************************
    logic voiceFlag_q;
    wire  detect   = vadEn && bits.rawValid && (preMag > VAD_THRESH);
    wire  flagClr  = wrStat && hwdata[ST_FLAG_BIT];

    // a detection in the clearing cycle keeps the flag set
    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            voiceFlag_q <= 1'b0;
        else if (detect)
            voiceFlag_q <= 1'b1;
        else if (flagClr)
            voiceFlag_q <= 1'b0;

    assign voiceAlert = voiceFlag_q && vadEn && (vadResp != RESP_WAKE);

    always_ff @(posedge clock or negedge nrst)
        if (!nrst)
            state_q <= REC_RUN;
        else
            case (state_q)
                REC_RUN:    if (vadEn && vadResp == RESP_WAKE) state_q <= REC_LISTEN;
                REC_LISTEN: if (!vadEn) state_q <= REC_RUN;
                            else if (detect) state_q <= REC_WOKEN;
                REC_WOKEN:  if (!vadEn) state_q <= REC_RUN;
                default:    state_q <= REC_RUN;
            endcase

    // ****************************************
    // read mux
    // ****************************************
    wire [31:0] statusWord = {17'h0, recording, analogPowerDown, agcGain_q,
                              3'h0, voiceFlag_q, chDigital};
    assign rdMux = (haddr[7:0] == REG_CLK_CFG)  ? {24'h0, clkCfg_q} :
                   (haddr[7:0] == REG_EDGE_CFG) ? {24'h0, edgeSel_q, 4'h0} :
                   (haddr[7:0] == REG_CH1_CFG)  ? {25'h0, ch1Src_q, 5'h0} :
                   (haddr[7:0] == REG_CH2_CFG)  ? {25'h0, ch2Src_q, 5'h0} :
                   (haddr[7:0] == REG_VAD_CFG)  ? {24'h0, vadCfg_q} :
                   (haddr[7:0] == REG_AGC_CFG)  ? {19'h0, agcCfg_q} :
                   (haddr[7:0] == REG_STATUS)   ? statusWord : 32'h0;

    // ****************************************
    // checks
    // ****************************************
    fast48_period_a : assert property (@(posedge clock) disable iff (!nrst || wrClk)
        rise && divSel == 2'h0 && !family44 |=> !rise[*8] ##1 !rise[*7] ##[1:2] rise)
        else $error("6.144 MHz bit clock period out of range");
    fast44_period_a : assert property (@(posedge clock) disable iff (!nrst || wrClk)
        rise && divSel == 2'h0 && family44 |=> !rise[*8] ##1 !rise[*8] ##[1:2] rise)
        else $error("5.6448 MHz bit clock period out of range");
    aux_clock_out_a : assert property (@(posedge clock) disable iff (!nrst)
        rise && clkCfg_q[CLK_AUXO_BIT] && ch2Free |-> auxOutputPinFirst ##1 auxOutputPinFirst)
        else $error("bit clock missing on aux output");
    edge_choice_a : assert property (@(posedge clock) disable iff (!nrst)
        bits.bitStrobe[0] |-> (edgeSel_q[0] ? $rose(micClk) : $fell(micClk)))
        else $error("channel one sampled on wrong edge");
    stream_split_a : assert property (@(posedge clock) disable iff (!nrst)
        edgeSel_q[0] != edgeSel_q[1] |-> !(bits.bitStrobe[0] && bits.bitStrobe[1]))
        else $error("both streams of one line sampled together");
    analog_off_a : assert property (@(posedge clock) disable iff (!nrst)
        $rose(ch1Src_q == SRC_DIGITAL) |-> analogPowerDown[0])
        else $error("analog path not powered down for digital source");
    ch3_digital_a : assert property (@(posedge clock) disable iff (!nrst)
        bits.rawValid && !chDigital[2] |=> pcmOut[2*PCM_W +: PCM_W] == '0)
        else $error("channel three carries a non-digital sample");
    wake_record_a : assert property (@(posedge clock) disable iff (!nrst)
        state_q == REC_LISTEN && detect |=> state_q == REC_WOKEN ##1 recording)
        else $error("voice detection did not wake recording");
    vad_alert_a : assert property (@(posedge clock) disable iff (!nrst)
        detect && vadResp == RESP_IRQ && !wrVad |=> voiceAlert)
        else $error("voice detection did not raise alert");
    gain_cap_a : assert property (@(posedge clock) disable iff (!nrst)
        agcEn && $stable(maxGain) |-> (agcGain_q <= maxGain) or ##1 (agcGain_q == maxGain))
        else $error("automatic gain above maximum");

endmodule : pdm_mic_record

// [dv/mic_pair_model.sv]
`timescale 1ns/10ps
module mic_pair_model #(
    parameter logic BIT_ON_RISE = 1'b1,
    parameter logic BIT_ON_FALL = 1'b0
)(
    input  wire logic micClk,
    output logic      micData
);
    // ****************************************
    // two mics sharing one data line
    // ****************************************
    // 40 ns launch delay keeps the line steady across the sampling edge
    initial micData = 1'b0;
    always @(negedge micClk) micData <= #40 BIT_ON_RISE;
    always @(posedge micClk) micData <= #40 BIT_ON_FALL;
endmodule : mic_pair_model

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import pdm_rec_pkg::*;
    // ****************************************
    // stimulus, bus master and result queue
    // ****************************************
    logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, rdPhase = 0, hreadyout, hresp, prevClk = 0;
    logic [1:0] htrans = 2'h0, analogPowerDown;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, analogPcm = 32'h0, hrdata;
    logic [63:0] expQ [$], pcmOut;
    logic [7:0] seed = 8'h34;
    logic auxOutputPinFirst, bidirAuxPinOut, bidirAuxPinOe_n, voiceAlert, pcmValid;
    logic dataFirst, dataSecond;
    int mismatches = 0, cmp_count = 0, n;
    real expEdges, expAmp;
    always #5 clock = ~clock;
    mic_pair_model micA (.micClk(auxOutputPinFirst), .micData(dataFirst));
    mic_pair_model micB (.micClk(auxOutputPinFirst), .micData(dataSecond));
    pdm_mic_record dut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .auxInputPinFirst(dataFirst), .micBiasPinIn(dataSecond),
        .auxOutputPinFirst(auxOutputPinFirst), .bidirAuxPinIn(dataSecond),
        .bidirAuxPinOut(bidirAuxPinOut), .bidirAuxPinOe_n(bidirAuxPinOe_n),
        .analogPcm(analogPcm), .analogPowerDown(analogPowerDown), .voiceAlert(voiceAlert),
        .pcmValid(pcmValid), .pcmOut(pcmOut));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; rdPhase <= ~wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rdPhase <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_for(input int which);
        int i;
        for (i = 0; i < 5000 && (which ? voiceAlert : pcmValid) !== 1'b1; i++) @(negedge clock);
    endtask : wait_for
    always @(posedge clock)
    begin
        if (rdPhase === 1'b1 && expQ.size() > 0)
        begin
            logic [63:0] e;
            e = expQ.pop_front();
            check((hrdata & e[63:32]) === e[31:0] && hresp === 1'b0, "read data");
        end
    end
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #600000;
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        rd(REG_AGC_CFG, {24'h0, GAIN_CTRL_TARGET_LEVEL_RST, AGC_MAX_RST}, 32'hFF);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF);
        seed = lfsr(seed);
        bus(1'b1, REG_EDGE_CFG, {24'h0, seed[7:4], 4'h0});
        rd(REG_EDGE_CFG, {24'h0, seed[7:4], 4'h0}, 32'hF0);
        bus(1'b1, REG_CH1_CFG, 32'h20);
        bus(1'b1, REG_CH2_CFG, 32'h20);
        @(negedge clock);
        check(analogPowerDown === 2'b11, "analog path still powered");
        rd(REG_STATUS, 32'h3000, 32'h3000);
        $display("registers and sources done");
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, REG_CLK_CFG, 32'h08 | k);
            n = 0;
            repeat (2000)
            begin
                @(negedge clock);
                n += (auxOutputPinFirst === 1'b1 && prevClk === 1'b0);
                prevClk = auxOutputPinFirst;
            end
            expEdges = (k[2] ? MIC_MHZ_44 : MIC_MHZ_48) * 20.0 / (1 << k[1:0]);
            check(n >= expEdges - 1.0 && n <= expEdges + 1.0, "bit clock rate");
        end
        $display("bit clock rates done");
        bus(1'b1, REG_CLK_CFG, 32'hC8);
        bus(1'b1, REG_EDGE_CFG, 32'h10);
        repeat (2)
        begin
            @(negedge clock);
            wait_for(0);
        end
        check($signed(pcmOut[15:0]) > 0 && $signed(pcmOut[31:16]) < 0, "stream split");
        check($signed(pcmOut[47:32]) < 0 && $signed(pcmOut[63:48]) < 0, "ch3/4");
        $display("shared line split done");
        bus(1'b1, REG_VAD_CFG, 32'h01);
        wait_for(1);
        check(voiceAlert === 1'b1, "voice not flagged");
        bus(1'b1, REG_VAD_CFG, 32'h00);
        @(negedge clock);
        check(voiceAlert === 1'b0, "alert while disabled");
        $display("voice detection done");
        bus(1'b1, REG_CH1_CFG, 32'h00);
        seed = lfsr(seed);
        analogPcm <= {24'h0, seed};
        repeat (2)
        begin
            @(negedge clock);
            wait_for(0);
        end
        check(analogPowerDown === 2'b10, "analog path off");
        expAmp = seed * 1.4125;
        n = $signed(pcmOut[15:0]);
        check(n > expAmp - 2.0 && n < expAmp + 2.0, "analog level");
        bus(1'b1, REG_AGC_CFG, 32'h1002);
        repeat (4)
        begin
            @(negedge clock);
            wait_for(0);
        end
        rd(REG_STATUS, 32'h200, 32'hF00);
        bus(1'b1, REG_CLK_CFG, 32'h18);
        @(negedge clock);
        check(bidirAuxPinOe_n === 1'b0, "bidir pin not driven");
        check(bidirAuxPinOut === auxOutputPinFirst, "bidir clock");
        $display("analog, gain control and pins done");
        tally_and_finish();
    end
endmodule : tb_top
